// ===== rtl/wdrc_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog.
// Assumes byte addresses on an Avalon-MM slave with 32-bit data.
`ifndef WDRC_DEFINES_SVH
`define WDRC_DEFINES_SVH

`define WDRC_CTRL_OFS 8'h60
`define WDRC_CAUSE_OFS 8'h64

`define WDRC_B_IRQ_FLAG 7
`define WDRC_B_IRQ_EN 6
`define WDRC_B_SEL3 5
`define WDRC_B_UNLOCK 4
`define WDRC_B_RST_EN 3

`define WDRC_B_WD_CAUSE 3
`define WDRC_B_BO_CAUSE 2
`define WDRC_B_PIN_CAUSE 1
`define WDRC_B_PO_CAUSE 0

`define WDRC_CAUSE_RST 4'h1
`define WDRC_UNLOCK_CYC 3'h4
`define WDRC_BASE_TICKS 2048
`define WDRC_SEL_MAX 4'h9

`endif

// ===== rtl/wdrc_pkg.sv
// Types shared by the watchdog design.
// Assumes nothing of its surroundings.
`default_nettype none

package wdrc_pkg;

  typedef enum logic [3:0] {
    WDRC_STOP = 4'b0001,
    WDRC_IRQ = 4'b0010,
    WDRC_RST = 4'b0100,
    WDRC_BOTH = 4'b1000
  } wdrc_mode_t;

endpackage

`default_nettype wire

// ===== rtl/wdrc_top.sv
// Watchdog with reset-cause flags, Avalon-MM slave, one 200 MHz clock.
// Assumes the oscillator, fuse and reset events arrive as asynchronous pins.
//
// How it works
// - Time-out in interrupt mode sets flag bit 7
// - Vector execution or writing one clears flag
// - Interrupt needs global enable and bit 6
// - Reset and interrupt enables select the mode
// - Programmed fuse forces system reset mode
// - Combined mode: vector clears enable and flag
// - Combined mode: second unserviced time-out resets
// - Clearing reset enable or period needs unlock
// - Unlock bit self-clears four cycles later
// - Reset enable reads set while cause set
// - Period select at bits 5 and 2:0
// - Watchdog cause set by watchdog reset
// - Brown-out cause set by brown-out reset
// - Pin cause set by external pin reset
// - Power-on cause cleared only by software
// - Cause register bits 7:4 read zero
// - Counter counts separate slow oscillator ticks
// - Restart input clears the counter
// - Reset mode time-out gives one-cycle reset
`default_nettype none

`include "wdrc_defines.svh"

module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int BASE_TICKS = `WDRC_BASE_TICKS,
  parameter int CNT_W = 20
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic wd_osc_in,
  input wire logic wd_force_on_fuse_in,
  input wire logic brownout_rst_in,
  input wire logic pin_rst_in,
  input wire logic core_irq_enable_in,
  input wire logic wd_vector_ack_in,
  input wire logic wd_restart_in,
  output logic wd_irq_out,
  output logic sys_reset_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] st_q;
  logic [3:0] st_d;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q <= 4'h4;
      s2_q <= 4'h4;
      s3_q <= 4'h4;
      st_q <= 4'h4;
    end else begin
      s1_q <= {pin_rst_in, wd_force_on_fuse_in, brownout_rst_in, wd_osc_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
    end
  end

  logic osc_tick;
  logic bo_evt;
  logic pin_evt;
  logic fuse_unprog;
  assign osc_tick = st_d[0] && !st_q[0];
  assign bo_evt = st_d[1] && !st_q[1];
  assign pin_evt = st_d[3] && !st_q[3];
  assign fuse_unprog = st_q[2];

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle

  logic wait_q;
  logic req;
  logic acc_wr;
  logic [7:0] wd;
  logic ctl_wr;
  logic cause_wr;
  assign req = avs_read_in || avs_write_in;
  assign acc_wr = avs_write_in && !wait_q && avs_byteenable_in[0];
  assign wd = avs_writedata_in[7:0];
  assign ctl_wr = acc_wr && (avs_address_in == `WDRC_CTRL_OFS);
  assign cause_wr = acc_wr && (avs_address_in == `WDRC_CAUSE_OFS);
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  assign avs_waitrequest_out = wait_q;

  ////////////////////////////////////////////////////////////////////////
  // Control state

  logic irq_flag_q;
  logic irq_en_q;
  logic wde_q;
  logic [3:0] sel_q;
  logic [2:0] unlock_q;
  logic [3:0] cause_q;
  logic rst_evt;
  logic unlock_wr;
  logic unlocked;
  logic wde_eff;
  wdrc_mode_t mode;
  assign rst_evt = sys_reset_out || bo_evt || pin_evt;
  assign unlock_wr = ctl_wr && wd[`WDRC_B_UNLOCK] && wd[`WDRC_B_RST_EN];
  assign unlocked = unlock_q != 3'h0;
  assign wde_eff = wde_q || cause_q[`WDRC_B_WD_CAUSE];
  always_comb begin
    if (!fuse_unprog) begin
      mode = WDRC_RST;
    end else if (wde_eff && irq_en_q) begin
      mode = WDRC_BOTH;
    end else if (wde_eff) begin
      mode = WDRC_RST;
    end else if (irq_en_q) begin
      mode = WDRC_IRQ;
    end else begin
      mode = WDRC_STOP;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_q <= 3'h0;
    end else if (rst_evt) begin
      unlock_q <= 3'h0;
    end else if (unlock_wr) begin
      unlock_q <= `WDRC_UNLOCK_CYC;
    end else if (unlocked) begin
      unlock_q <= unlock_q - 3'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wde_q <= 1'b0;
      sel_q <= 4'h0;
    end else if (rst_evt) begin
      wde_q <= 1'b0;
      sel_q <= 4'h0;
    end else if (ctl_wr && unlocked) begin
      wde_q <= wd[`WDRC_B_RST_EN];
      sel_q <= {wd[`WDRC_B_SEL3], wd[2:0]};
    end else if (ctl_wr && wd[`WDRC_B_RST_EN]) begin
      wde_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time-out counter

  function automatic logic [CNT_W-1:0] period_top(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `WDRC_SEL_MAX) ? `WDRC_SEL_MAX : sel;
    return CNT_W'((BASE_TICKS << s) - 1);
  endfunction
  logic [CNT_W-1:0] cnt_q;
  logic running;
  logic tmo;
  logic irq_set;
  logic escalate;
  assign running = mode != WDRC_STOP;
  assign tmo = osc_tick && running && (cnt_q >= period_top(sel_q));
  assign irq_set = tmo && ((mode == WDRC_IRQ) || (mode == WDRC_BOTH && !irq_flag_q));
  assign escalate = tmo && ((mode == WDRC_RST) || (mode == WDRC_BOTH && irq_flag_q));
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (rst_evt || wd_restart_in || tmo || !running) begin
      cnt_q <= '0;
    end else if (osc_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flag, enable and output

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_flag_q <= 1'b0;
    end else if (rst_evt) begin
      irq_flag_q <= 1'b0;
    end else if (irq_set) begin
      irq_flag_q <= 1'b1;
    end else if (wd_vector_ack_in || (ctl_wr && wd[`WDRC_B_IRQ_FLAG])) begin
      irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_en_q <= 1'b0;
    end else if (rst_evt) begin
      irq_en_q <= 1'b0;
    end else if (wd_vector_ack_in && mode == WDRC_BOTH) begin
      irq_en_q <= 1'b0;
    end else if (ctl_wr) begin
      irq_en_q <= wd[`WDRC_B_IRQ_EN];
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wd_irq_out <= 1'b0;
    end else begin
      wd_irq_out <= irq_flag_q && irq_en_q && core_irq_enable_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sys_reset_out <= 1'b0;
    end else begin
      sys_reset_out <= escalate;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset-cause flags

  logic [3:0] cause_set;

  assign cause_set = {sys_reset_out, bo_evt, pin_evt, 1'b0};

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cause_q <= `WDRC_CAUSE_RST;
    end else begin
      cause_q <= cause_set | (cause_q & (cause_wr ? wd[3:0] : 4'hF));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] ctrl_rd;
  assign ctrl_rd = {irq_flag_q, irq_en_q, sel_q[3], unlocked, wde_eff, sel_q[2:0]};
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && wait_q) begin
      if (avs_address_in == `WDRC_CTRL_OFS) begin
        avs_readdata_out <= {24'h0, ctrl_rd};
      end else if (avs_address_in == `WDRC_CAUSE_OFS) begin
        avs_readdata_out <= {28'h0, cause_q};
      end else begin
        avs_readdata_out <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sequence unlock_quiet_s;
    (!rst_evt && !unlock_wr) [*4];
  endsequence
  sequence unlock_closed_s;
    !unlocked;
  endsequence

  irq_flag_set_a: assert property (
    irq_set && !rst_evt |=> irq_flag_q)
    else $error("flag not set on time-out");
  irq_gate_a: assert property (
    wd_irq_out |-> $past(irq_flag_q && irq_en_q && core_irq_enable_in))
    else $error("interrupt without enables");
  fuse_mode_a: assert property (
    !fuse_unprog && tmo |=> sys_reset_out)
    else $error("fuse does not force reset mode");
  unlock_life_a: assert property (
    (unlock_wr && !rst_evt) ##1 unlock_quiet_s |->
      (unlocked && $past(unlocked, 3)) ##1 unlock_closed_s)
    else $error("unlock window length wrong");
  locked_wde_a: assert property (
    ctl_wr && !unlocked && !wd[`WDRC_B_RST_EN] && wde_q && !rst_evt |=> wde_q)
    else $error("reset enable cleared while locked");
  combined_escalate_a: assert property (
    tmo && mode == WDRC_BOTH && irq_flag_q |=> sys_reset_out ##1 cause_q[3])
    else $error("no reset on second time-out");
  reset_pulse_a: assert property (
    sys_reset_out |=> !sys_reset_out)
    else $error("reset pulse longer than one cycle");
  wde_held_a: assert property (
    cause_q[`WDRC_B_WD_CAUSE] |-> wde_eff && mode != WDRC_STOP && mode != WDRC_IRQ)
    else $error("reset enable not held by cause flag");
  restart_a: assert property (
    wd_restart_in |=> cnt_q == '0)
    else $error("restart did not clear counter");
  cause_zero_a: assert property (
    avs_read_in && wait_q && avs_address_in == `WDRC_CAUSE_OFS |=>
      !avs_waitrequest_out && avs_readdata_out[31:4] == 28'h0)
    else $error("cause read wrong");

endmodule

`default_nettype wire

// ===== testbench/wdrc_osc_model.sv
// Slow oscillator model for the watchdog bench.
// Assumes the bench samples it with a much faster system clock.
`default_nettype none
module wdrc_osc_model #(parameter int HALF_NS = 50) (
  output logic osc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free-running separate oscillator
  initial begin
    osc_out = 1'b0;
    forever #(HALF_NS) osc_out = ~osc_out;
  end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench: register rows, modes, unlock, reset causes.
// Assumes wdrc_top, its package and the oscillator model are compiled.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 20;
  localparam logic [7:0] C = 8'h60;
  localparam logic [7:0] S = 8'h64;
  logic clock_in, rst_b_in, rd, wr, fuse, bo, pin, gie, ack, rs, osc, irq, srst, wq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  int err_total = 0;
  int n_checks = 0;
  int n;
  // Address, write data, expected read back
  logic [23:0] rows [5] = '{24'h640000, 24'h604040, 24'h602500, 24'h70FF00, 24'h64FF00};
  wdrc_top #(.BASE_TICKS(4), .CNT_W(20)) wdrc_top_i (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wq), .wd_osc_in(osc), .wd_force_on_fuse_in(fuse),
    .brownout_rst_in(bo), .pin_rst_in(pin), .core_irq_enable_in(gie),
    .wd_vector_ack_in(ack), .wd_restart_in(rs), .wd_irq_out(irq), .sys_reset_out(srst));
  wdrc_osc_model #(.HALF_NS(50)) wdrc_osc_model_i (.osc_out(osc));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clock_in);
      k++;
    end while (wq !== 1'b0 && k < 50);
    if (k >= 50) chk("waitrequest", wq, 0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, rv, {24'h0, e});
  endtask
  task automatic wait_on(input logic which, input int max);
    n = 0;
    while ((which ? srst : irq) !== 1'b1 && n < max) begin
      @(posedge clock_in);
      n++;
    end
  endtask
  task automatic pulse(input int which);
    @(posedge clock_in);
    if (which == 0) rs <= 1'b1;
    else ack <= 1'b1;
    @(posedge clock_in);
    rs <= 1'b0;
    ack <= 1'b0;
  endtask
  task automatic unlock(input logic [7:0] d);
    pulse(0);
    bus(1'b1, C, 8'h18);
    bus(1'b1, C, d);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    chk("watchdog", 0, 1);
    conclude;
  end
  initial begin
    {rd, wr, fuse, bo, pin, gie, ack, rs} = 8'b0010_0000;
    addr = 8'h00;
    wdata = 32'h0;
    rst_b_in = 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rdchk("control reset", C, 8'h00);
    rdchk("cause reset", S, 8'h01);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][23:16], rows[i][15:8]);
      rdchk("row", rows[i][23:16], rows[i][7:0]);
    end
    unlock(8'h21);
    rdchk("period field", C, 8'h21);
    gie <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      unlock(8'h40 | 8'(s));
      pulse(0);
      wait_on(1'b0, 2000);
      chk("period", n >= (4 << s) * P - P && n <= (4 << s) * P + 2 * P, 1);
      rdchk("irq flag", C, 8'hC0 | 8'(s));
      bus(1'b1, C, 8'hC0 | 8'(s));
      rdchk("flag w1c", C, 8'h40 | 8'(s));
    end
    unlock(8'h40);
    gie <= 1'b0;
    repeat (10) begin
      pulse(0);
      repeat (40) @(posedge clock_in);
    end
    rdchk("restart holds off", C, 8'h40);
    repeat (200) @(posedge clock_in);
    chk("masked irq", irq, 0);
    rdchk("flag while masked", C, 8'hC0);
    gie <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk("irq out", irq, 1);
    pulse(0);
    pulse(1);
    rdchk("vector clears flag", C, 8'h40);
    unlock(8'h48);
    wait_on(1'b0, 400);
    chk("no early reset", srst, 0);
    pulse(1);
    rdchk("combined ack", C, 8'h08);
    bus(1'b1, C, 8'h48);
    wait_on(1'b0, 400);
    wait_on(1'b1, 400);
    chk("reset seen", srst, 1);
    @(posedge clock_in);
    chk("reset pulse", srst, 0);
    rdchk("wd cause", S, 8'h08);
    rdchk("enable held", C, 8'h08);
    unlock(8'h00);
    rdchk("enable locked", C, 8'h08);
    bus(1'b1, S, 8'h00);
    unlock(8'h00);
    rdchk("enable cleared", C, 8'h00);
    pulse(0);
    bus(1'b1, C, 8'h08);
    bus(1'b1, C, 8'h00);
    rdchk("locked clear", C, 8'h08);
    bus(1'b1, C, 8'h18);
    repeat (4) @(posedge clock_in);
    bus(1'b1, C, 8'h00);
    rdchk("window closed", C, 8'h08);
    unlock(8'h00);
    fuse <= 1'b0;
    wait_on(1'b1, 400);
    chk("fuse forced reset", srst, 1);
    fuse <= 1'b1;
    bus(1'b1, S, 8'h00);
    unlock(8'h00);
    bo <= 1'b1;
    repeat (8) @(posedge clock_in);
    bo <= 1'b0;
    rdchk("brown-out cause", S, 8'h04);
    pin <= 1'b1;
    repeat (8) @(posedge clock_in);
    pin <= 1'b0;
    rdchk("pin cause", S, 8'h06);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rdchk("power-on cause", S, 8'h01);
    conclude;
  end
endmodule
`default_nettype wire
